// *** design/umd_pkg.sv ***
// Package of constants and types for the multidrop direction control block
// Summary of operation
// - Normal multidrop: ninth bit marks address, flags parity error
// - Receiver disabled: drop data, keep addresses, data ready
// - Receiver enabled: store all, parity error on addresses
// - Auto address needs multidrop and auto enable
// - Auto mode compares addresses to match register
// - Disabled auto mode discards data and foreign addresses
// - Matching address stored, receiver enabled, data ready
// - Foreign address disables receiver, is not stored
// - Direction control only when bit four set
// - Select bit chooses RTS or DTR pin
// - Normal polarity: low while sending, high after
// - Inverted polarity: high while sending, low after
// - Direction enable beats other sources except loopback
// - Hold direction 0 to 255 baud periods after stop
// - Divisor registers produce sixteen times oversample enable
// - Receiver disable is bit one, resets zero
`default_nettype none
package umd_pkg;
    localparam logic [31:0] ADDR_MULTIDROP_CONTROL          = 32'h4000_804c;
    localparam logic [31:0] ADDR_MULTIDROP_ADDRESS_MATCH    = 32'h4000_8050;
    localparam logic [31:0] ADDR_DIRECTION_TURNAROUND_DELAY = 32'h4000_8054;
    localparam logic [31:0] ADDR_DIVISOR_LOW                = 32'h4000_8058;
    localparam logic [31:0] ADDR_DIVISOR_HIGH               = 32'h4000_805c;

    localparam int BIT_MULTIDROP_ENABLE     = 0;
    localparam int BIT_RECEIVER_DISABLE     = 1;
    localparam int BIT_AUTO_ADDRESS_ENABLE  = 2;
    localparam int BIT_DIR_PIN_SELECT       = 3;
    localparam int BIT_AUTO_DIR_ENABLE      = 4;
    localparam int BIT_DIR_POLARITY_INVERT  = 5;
    localparam int CONTROL_WIDTH            = 6;

    localparam logic [5:0]  CONTROL_RESET       = 6'h00;
    localparam logic [7:0]  ADDRESS_MATCH_RESET = 8'h00;
    localparam logic [7:0]  DELAY_RESET         = 8'h00;
    localparam logic [7:0]  DIVISOR_LOW_RESET   = 8'h01;
    localparam logic [7:0]  DIVISOR_HIGH_RESET  = 8'h00;
    localparam logic [3:0]  OVERSAMPLE_LAST     = 4'hf;

    typedef enum logic [1:0] {
        DIR_IDLE,
        DIR_ARMED,
        DIR_SENDING,
        DIR_HOLD
    } umd_dir_state_e;
endpackage : umd_pkg
`default_nettype wire

// *** design/umd_baud_if.sv ***
// Interface between the register block and the baud generator
`default_nettype none
interface umd_baud_if;
    logic [15:0] divisor;
    logic        oversample_enable;
    modport ctrl (output divisor, input  oversample_enable);
    modport gen  (input  divisor, output oversample_enable);
endinterface : umd_baud_if
`default_nettype wire

// *** design/umd_baud_gen.sv ***
// Baud generator: sixteen times oversample enable from the divisor
`default_nettype none
module umd_baud_gen (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    // Divisor and enable
    umd_baud_if.gen   baud
);
    logic [15:0] count;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= 16'h0000;
        end else if (baud.divisor == 16'h0000) begin
            count <= 16'h0000;
        end else if (count >= baud.divisor - 16'h0001) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            baud.oversample_enable <= 1'b0;
        end else begin
            baud.oversample_enable <= (baud.divisor != 16'h0000)
                && (count >= baud.divisor - 16'h0001);
        end
    end
endmodule : umd_baud_gen
`default_nettype wire

// *** design/umd_multidrop.sv ***
// Multidrop receive filter, direction pin control and their registers
`default_nettype none
module umd_multidrop (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Received characters from the receiver
    input  wire logic        rx_char_valid_i,
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        rx_ninth_i,
    // Characters to the receive FIFO and events
    output logic             rx_store_o,
    output logic      [8:0]  rx_store_data_o,
    output logic             rx_data_ready_o,
    output logic             rx_parity_error_o,
    // Transmitter status
    input  wire logic        tx_fifo_write_i,
    input  wire logic        tx_idle_i,
    // Other direction pin sources
    input  wire logic        loopback_i,
    input  wire logic        modem_rts_i,
    input  wire logic        modem_dtr_i,
    // Pins and timing
    output logic             rts_o,
    output logic             dtr_o,
    output logic             oversample_enable_o
);
    umd_baud_if baud ();

    logic [umd_pkg::CONTROL_WIDTH-1:0] control;
    logic [7:0]                        address_match_value;
    logic [7:0]                        dir_deassert_delay;
    logic [7:0]                        divisor_low;
    logic [7:0]                        divisor_high;
    logic                              wr_en;
    logic                              rd_setup;
    logic                              hit;
    logic                              multidrop_enable;
    logic                              receiver_disable;
    logic                              auto_address_detect;
    logic                              normal_multidrop_mode;
    logic                              is_address;
    logic                              addr_match;
    logic                              next_store;
    logic                              next_ready;
    logic                              next_parity;
    logic                              hw_set_receiver_disable;
    logic                              hw_clr_receiver_disable;
    umd_pkg::umd_dir_state_e           dir_state;
    umd_pkg::umd_dir_state_e           next_dir_state;
    logic [7:0]                        delay_count;
    logic [3:0]                        sub_count;
    logic                              dir_active;
    logic                              dir_level;

    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] b);
        addr_is = (a == b);
    endfunction : addr_is

    assign multidrop_enable      = control[umd_pkg::BIT_MULTIDROP_ENABLE];
    assign receiver_disable      = control[umd_pkg::BIT_RECEIVER_DISABLE];
    assign auto_address_detect   = multidrop_enable
                                   && control[umd_pkg::BIT_AUTO_ADDRESS_ENABLE];
    assign normal_multidrop_mode = multidrop_enable && !auto_address_detect;
    assign is_address            = rx_ninth_i;
    assign addr_match            = (rx_char_i == address_match_value);

    // Bus decode
    assign hit = addr_is(paddr_i, umd_pkg::ADDR_MULTIDROP_CONTROL)
              || addr_is(paddr_i, umd_pkg::ADDR_MULTIDROP_ADDRESS_MATCH)
              || addr_is(paddr_i, umd_pkg::ADDR_DIRECTION_TURNAROUND_DELAY)
              || addr_is(paddr_i, umd_pkg::ADDR_DIVISOR_LOW)
              || addr_is(paddr_i, umd_pkg::ADDR_DIVISOR_HIGH);
    assign wr_en     = psel_i && penable_i && pwrite_i && hit;
    assign rd_setup  = psel_i && !penable_i && !pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;

    // Read data captured in the setup phase
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_o <= 32'h0000_0000;
            if (addr_is(paddr_i, umd_pkg::ADDR_MULTIDROP_CONTROL)) begin
                prdata_o[umd_pkg::CONTROL_WIDTH-1:0] <= control;
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_MULTIDROP_ADDRESS_MATCH)) begin
                prdata_o[7:0] <= address_match_value;
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_DIRECTION_TURNAROUND_DELAY)) begin
                prdata_o[7:0] <= dir_deassert_delay;
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_DIVISOR_LOW)) begin
                prdata_o[7:0] <= divisor_low;
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_DIVISOR_HIGH)) begin
                prdata_o[7:0] <= divisor_high;
            end
        end
    end

    // Receive filter decision
    always_comb begin
        next_store   = 1'b0;
        next_ready   = 1'b0;
        next_parity  = 1'b0;
        hw_set_receiver_disable = 1'b0;
        hw_clr_receiver_disable = 1'b0;
        if (rx_char_valid_i) begin
            if (auto_address_detect) begin
                if (is_address && addr_match) begin
                    next_store   = 1'b1;
                    next_ready   = 1'b1;
                    hw_clr_receiver_disable = 1'b1;
                end else if (is_address) begin
                    hw_set_receiver_disable = !receiver_disable;
                end else begin
                    next_store = !receiver_disable;
                    next_ready = !receiver_disable;
                end
            end else if (normal_multidrop_mode) begin
                if (receiver_disable) begin
                    next_store = is_address;
                    next_ready = is_address;
                end else begin
                    next_store = 1'b1;
                    next_ready = 1'b1;
                end
                next_parity = is_address;
            end else begin
                next_store = 1'b1;
                next_ready = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_store_o        <= 1'b0;
            rx_data_ready_o   <= 1'b0;
            rx_parity_error_o <= 1'b0;
            rx_store_data_o   <= 9'h000;
        end else begin
            rx_store_o        <= next_store;
            rx_data_ready_o   <= next_ready;
            rx_parity_error_o <= next_parity;
            if (next_store) begin
                rx_store_data_o <= {rx_ninth_i, rx_char_i};
            end
        end
    end

    // Control register; hardware changes to the receiver disable win over writes
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            control <= umd_pkg::CONTROL_RESET;
        end else begin
            if (wr_en && addr_is(paddr_i, umd_pkg::ADDR_MULTIDROP_CONTROL)) begin
                control <= pwdata_i[umd_pkg::CONTROL_WIDTH-1:0];
            end
            if (hw_set_receiver_disable) begin
                control[umd_pkg::BIT_RECEIVER_DISABLE] <= 1'b1;
            end else if (hw_clr_receiver_disable) begin
                control[umd_pkg::BIT_RECEIVER_DISABLE] <= 1'b0;
            end
        end
    end

    // Match, delay and divisor registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            address_match_value <= umd_pkg::ADDRESS_MATCH_RESET;
            dir_deassert_delay  <= umd_pkg::DELAY_RESET;
            divisor_low         <= umd_pkg::DIVISOR_LOW_RESET;
            divisor_high        <= umd_pkg::DIVISOR_HIGH_RESET;
        end else if (wr_en) begin
            if (addr_is(paddr_i, umd_pkg::ADDR_MULTIDROP_ADDRESS_MATCH)) begin
                address_match_value <= pwdata_i[7:0];
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_DIRECTION_TURNAROUND_DELAY)) begin
                dir_deassert_delay <= pwdata_i[7:0];
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_DIVISOR_LOW)) begin
                divisor_low <= pwdata_i[7:0];
            end
            if (addr_is(paddr_i, umd_pkg::ADDR_DIVISOR_HIGH)) begin
                divisor_high <= pwdata_i[7:0];
            end
        end
    end

    // Baud generator
    assign baud.divisor = {divisor_high, divisor_low};

    umd_baud_gen u_baud_gen (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .baud      (baud.gen)
    );

    assign oversample_enable_o = baud.oversample_enable;

    // Direction sequence: armed on a write, sending until idle, then hold, or straight to idle when the delay is zero
    always_comb begin
        next_dir_state = dir_state;
        unique case (dir_state)
            umd_pkg::DIR_IDLE: begin
                if (tx_fifo_write_i) begin
                    next_dir_state = umd_pkg::DIR_ARMED;
                end
            end
            umd_pkg::DIR_ARMED: begin
                if (!tx_idle_i) begin
                    next_dir_state = umd_pkg::DIR_SENDING;
                end
            end
            umd_pkg::DIR_SENDING: begin
                if (tx_fifo_write_i) begin
                    next_dir_state = umd_pkg::DIR_SENDING;
                end else if (tx_idle_i && dir_deassert_delay == 8'h00) begin
                    next_dir_state = umd_pkg::DIR_IDLE;
                end else if (tx_idle_i) begin
                    next_dir_state = umd_pkg::DIR_HOLD;
                end
            end
            umd_pkg::DIR_HOLD: begin
                if (tx_fifo_write_i) begin
                    next_dir_state = umd_pkg::DIR_ARMED;
                end else if (delay_count == 8'h00) begin
                    next_dir_state = umd_pkg::DIR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_state <= umd_pkg::DIR_IDLE;
        end else begin
            dir_state <= next_dir_state;
        end
    end

    // Turnaround counter in whole baud periods of sixteen oversample ticks
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            delay_count <= 8'h00;
            sub_count   <= 4'h0;
        end else if (dir_state != umd_pkg::DIR_HOLD) begin
            delay_count <= dir_deassert_delay;
            sub_count   <= 4'h0;
        end else if (baud.oversample_enable && delay_count != 8'h00) begin
            sub_count <= sub_count + 4'h1;
            if (sub_count == umd_pkg::OVERSAMPLE_LAST) begin
                delay_count <= delay_count - 8'h01;
            end
        end
    end

    assign dir_active = (dir_state != umd_pkg::DIR_IDLE);
    assign dir_level  = ~(dir_active ^ control[umd_pkg::BIT_DIR_POLARITY_INVERT]);

    // Pin drive with loopback first, then automatic direction, then modem sources
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rts_o <= 1'b1;
            dtr_o <= 1'b1;
        end else if (loopback_i) begin
            rts_o <= 1'b1;
            dtr_o <= 1'b1;
        end else if (control[umd_pkg::BIT_AUTO_DIR_ENABLE]) begin
            rts_o <= control[umd_pkg::BIT_DIR_PIN_SELECT] ? modem_rts_i : dir_level;
            dtr_o <= control[umd_pkg::BIT_DIR_PIN_SELECT] ? dir_level : modem_dtr_i;
        end else begin
            rts_o <= modem_rts_i;
            dtr_o <= modem_dtr_i;
        end
    end
endmodule : umd_multidrop
`default_nettype wire

// *** testbench/umd_multidrop_props.sv ***
// Port-level checker for the multidrop direction control block
`default_nettype none
module umd_multidrop_props (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    // Register bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    // Receive side
    input wire logic        rx_char_valid_i,
    input wire logic [7:0]  rx_char_i,
    input wire logic        rx_ninth_i,
    input wire logic        rx_store_o,
    input wire logic [8:0]  rx_store_data_o,
    input wire logic        rx_data_ready_o,
    input wire logic        rx_parity_error_o,
    // Transmit side and pins
    input wire logic        tx_fifo_write_i,
    input wire logic        tx_idle_i,
    input wire logic        loopback_i,
    input wire logic        rts_o,
    input wire logic        dtr_o,
    input wire logic        oversample_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]  ctl;
    logic [7:0]  adr, dly;
    logic [15:0] div, gap;
    logic        seen;
    wire logic   wr = psel_i && penable_i && pwrite_i;
    wire logic   dwr = wr && (paddr_i == umd_pkg::ADDR_DIVISOR_LOW || paddr_i == umd_pkg::ADDR_DIVISOR_HIGH);
    // Software view of the registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl <= umd_pkg::CONTROL_RESET;
            adr <= umd_pkg::ADDRESS_MATCH_RESET;
            dly <= umd_pkg::DELAY_RESET;
            div <= {umd_pkg::DIVISOR_HIGH_RESET, umd_pkg::DIVISOR_LOW_RESET};
        end else if (wr) begin
            case (paddr_i)
                umd_pkg::ADDR_MULTIDROP_CONTROL: ctl <= pwdata_i[5:0];
                umd_pkg::ADDR_MULTIDROP_ADDRESS_MATCH: adr <= pwdata_i[7:0];
                umd_pkg::ADDR_DIRECTION_TURNAROUND_DELAY: dly <= pwdata_i[7:0];
                umd_pkg::ADDR_DIVISOR_LOW: div[7:0] <= pwdata_i[7:0];
                umd_pkg::ADDR_DIVISOR_HIGH: div[15:8] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end
    // Cycles since the last oversample pulse
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap <= 16'h0000;
            seen <= 1'b0;
        end else begin
            gap <= oversample_enable_o ? 16'h0000 : gap + 16'h0001;
            seen <= dwr ? 1'b0 : (seen | oversample_enable_o);
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_store_pair; rx_store_o |-> rx_data_ready_o; endproperty
    a_store_pair: assert property (p_store_pair) else $error("store without data ready");
    property p_store_data;
        rx_store_o |-> $past(rx_char_valid_i) && rx_store_data_o == {$past(rx_ninth_i), $past(rx_char_i)};
    endproperty
    a_store_data: assert property (p_store_data) else $error("stored word wrong");
    property p_parity; rx_parity_error_o |-> $past(rx_char_valid_i && rx_ninth_i) && $past(ctl[0] && !ctl[2]); endproperty
    a_parity: assert property (p_parity) else $error("parity pulse without address");
    property p_nmm_addr; rx_char_valid_i && rx_ninth_i && ctl[0] && !ctl[2] |=> rx_store_o && rx_parity_error_o; endproperty
    a_nmm_addr: assert property (p_nmm_addr) else $error("address lost in normal mode");
    property p_aad_miss; rx_char_valid_i && rx_ninth_i && ctl[0] && ctl[2] && rx_char_i != adr |=> !rx_store_o; endproperty
    a_aad_miss: assert property (p_aad_miss) else $error("foreign address stored");
    property p_aad_hit; rx_char_valid_i && rx_ninth_i && ctl[0] && ctl[2] && rx_char_i == adr |=> rx_store_o; endproperty
    a_aad_hit: assert property (p_aad_hit) else $error("matching address dropped");
    property p_dir_arm; ctl[4] && tx_fifo_write_i && !loopback_i ##1 !loopback_i |=> (ctl[3] ? dtr_o : rts_o) == ctl[5]; endproperty
    a_dir_arm: assert property (p_dir_arm) else $error("direction pin not active");
    property p_loopback; loopback_i ##1 loopback_i |-> rts_o && dtr_o; endproperty
    a_loopback: assert property (p_loopback) else $error("loopback not overriding");
    property p_zero_dly;
        ctl[4] && !ctl[3] && dly == 8'h00 && $rose(tx_idle_i) && !tx_fifo_write_i ##1 !tx_fifo_write_i && !loopback_i
            |=> rts_o == !ctl[5];
    endproperty
    a_zero_dly: assert property (p_zero_dly) else $error("pin late after idle");
    property p_baud; oversample_enable_o && seen |-> gap == div - 16'h0001; endproperty
    a_baud: assert property (p_baud) else $error("oversample spacing wrong");
endmodule : umd_multidrop_props
bind umd_multidrop umd_multidrop_props u_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i), .rx_ninth_i(rx_ninth_i), .rx_store_o(rx_store_o),
    .rx_store_data_o(rx_store_data_o), .rx_data_ready_o(rx_data_ready_o), .rx_parity_error_o(rx_parity_error_o),
    .tx_fifo_write_i(tx_fifo_write_i), .tx_idle_i(tx_idle_i), .loopback_i(loopback_i), .rts_o(rts_o),
    .dtr_o(dtr_o), .oversample_enable_o(oversample_enable_o));
`default_nettype wire

// *** testbench/umd_line_model.sv ***
// Line-side model: master traffic into the receiver, transmitter progress
`default_nettype none
module umd_line_model (
    // Clock
    input  wire logic      ref_clk_i,
    // Received characters
    output var logic       rx_char_valid_o,
    output var logic [7:0] rx_char_o,
    output var logic       rx_ninth_o,
    // Transmitter status
    output var logic       tx_idle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {rx_char_valid_o, rx_char_o, rx_ninth_o, tx_idle_o} = 11'h001;
    end
    // One character; lines show the inverse once it is gone
    task automatic send_char(input logic [7:0] c, input logic is_addr);
        @(posedge ref_clk_i);
        rx_char_valid_o <= 1'b1;
        rx_char_o <= c;
        rx_ninth_o <= is_addr;
        @(posedge ref_clk_i);
        rx_char_valid_o <= 1'b0;
        rx_char_o <= ~c;
        rx_ninth_o <= ~is_addr;
    endtask : send_char
    task automatic transmit(input int cycles);
        @(posedge ref_clk_i);
        tx_idle_o <= 1'b0;
        repeat (cycles) @(posedge ref_clk_i);
        tx_idle_o <= 1'b1;
    endtask : transmit
endmodule : umd_line_model
`default_nettype wire

// *** testbench/uart_multidrop_direction_ctrl_tb_top.sv ***
// Self-checking bench for the multidrop direction control block
`default_nettype none
module uart_multidrop_direction_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic [31:0] paddr_i, pwdata_i, prdata_o, q, cv;
    logic        rx_char_valid_i, rx_ninth_i, rx_store_o, rx_data_ready_o, rx_parity_error_o;
    logic [7:0]  rx_char_i;
    logic [8:0]  rx_store_data_o;
    logic        tx_fifo_write_i, tx_idle_i, loopback_i, modem_rts_i, modem_dtr_i, rts_o, dtr_o, oversample_enable_o;
    int          failures, compares, n;
    umd_multidrop dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i), .rx_ninth_i(rx_ninth_i),
        .rx_store_o(rx_store_o), .rx_store_data_o(rx_store_data_o), .rx_data_ready_o(rx_data_ready_o),
        .rx_parity_error_o(rx_parity_error_o), .tx_fifo_write_i(tx_fifo_write_i), .tx_idle_i(tx_idle_i),
        .loopback_i(loopback_i), .modem_rts_i(modem_rts_i), .modem_dtr_i(modem_dtr_i), .rts_o(rts_o),
        .dtr_o(dtr_o), .oversample_enable_o(oversample_enable_o));
    umd_line_model u_line (.ref_clk_i(ref_clk_i), .rx_char_valid_o(rx_char_valid_i), .rx_char_o(rx_char_i),
        .rx_ninth_o(rx_ninth_i), .tx_idle_o(tx_idle_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // One bus transfer: setup, access, then release
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(q, exp, "read data");
    endtask : rdc
    task automatic wctl(input logic [31:0] d);
        apb(1'b1, umd_pkg::ADDR_MULTIDROP_CONTROL, d);
    endtask : wctl
    task automatic rx(input logic [7:0] c, input logic a, input logic st, input logic pe);
        u_line.send_char(c, a);
        #1;
        check({29'h0, rx_store_o, rx_data_ready_o, rx_parity_error_o}, {29'h0, st, st, pe}, "rx events");
        if (st) begin
            check({23'h0, rx_store_data_o}, {23'h0, a, c}, "rx word");
        end
    endtask : rx
    task automatic txw();
        @(posedge ref_clk_i);
        tx_fifo_write_i <= 1'b1;
        @(posedge ref_clk_i);
        tx_fifo_write_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask : txw
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        $display("BAD %0t run did not complete", $time);
        tally_and_finish();
    end
    initial begin
        {rst_b_i, psel_i, penable_i, pwrite_i, tx_fifo_write_i, loopback_i} = 6'h00;
        {modem_rts_i, modem_dtr_i} = 2'h3;
        paddr_i = 32'h0000_0000;
        pwdata_i = 32'h0000_0000;
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rdc(umd_pkg::ADDR_MULTIDROP_CONTROL, 32'h0000_0000);
        rdc(umd_pkg::ADDR_MULTIDROP_ADDRESS_MATCH, 32'h0000_0000);
        rdc(umd_pkg::ADDR_DIRECTION_TURNAROUND_DELAY, 32'h0000_0000);
        rdc(umd_pkg::ADDR_DIVISOR_LOW, 32'h0000_0001);
        rdc(32'h4000_8060, 32'h0000_0000);
        check({30'h0, e, pready_o}, 32'h3, "unmapped error");
        wctl(32'h0000_003f);
        rdc(umd_pkg::ADDR_MULTIDROP_CONTROL, 32'h0000_003f);
        $display("test registers done");
        wctl(32'h0000_0003);
        rx(8'h11, 1'b0, 1'b0, 1'b0);
        rx(8'h55, 1'b1, 1'b1, 1'b1);
        wctl(32'h0000_0001);
        rx(8'h12, 1'b0, 1'b1, 1'b0);
        rx(8'h56, 1'b1, 1'b1, 1'b1);
        wctl(32'h0000_0006);
        rx(8'h33, 1'b1, 1'b1, 1'b0);
        apb(1'b1, umd_pkg::ADDR_MULTIDROP_ADDRESS_MATCH, 32'h0000_005a);
        wctl(32'h0000_0007);
        rx(8'h13, 1'b0, 1'b0, 1'b0);
        rx(8'h33, 1'b1, 1'b0, 1'b0);
        rx(8'h5a, 1'b1, 1'b1, 1'b0);
        rdc(umd_pkg::ADDR_MULTIDROP_CONTROL, 32'h0000_0005);
        rx(8'h14, 1'b0, 1'b1, 1'b0);
        rx(8'h33, 1'b1, 1'b0, 1'b0);
        rdc(umd_pkg::ADDR_MULTIDROP_CONTROL, 32'h0000_0007);
        rx(8'h15, 1'b0, 1'b0, 1'b0);
        $display("test receive filter done");
        for (int i = 0; i < 4; i++) begin
            cv = 32'h0000_0010 | (i[0] ? 32'h0000_0008 : 32'h0) | (i[1] ? 32'h0000_0020 : 32'h0);
            wctl(cv);
            txw();
            check({31'h0, i[0] ? dtr_o : rts_o}, {31'h0, cv[5]}, "pin active");
            check({31'h0, i[0] ? rts_o : dtr_o}, 32'h1, "other pin");
            u_line.transmit(4);
            repeat (2) @(posedge ref_clk_i);
            #1;
            check({31'h0, i[0] ? dtr_o : rts_o}, {31'h0, !cv[5]}, "pin released");
        end
        $display("test direction pin done");
        apb(1'b1, umd_pkg::ADDR_DIVISOR_LOW, 32'h0000_0002);
        apb(1'b1, umd_pkg::ADDR_DIRECTION_TURNAROUND_DELAY, 32'h0000_0002);
        wctl(32'h0000_0010);
        txw();
        u_line.transmit(4);
        repeat (60) @(posedge ref_clk_i);
        #1;
        check({31'h0, rts_o}, 32'h0, "pin held");
        for (n = 0; n < 20 && rts_o !== 1'b1; n++) @(negedge ref_clk_i);
        check({31'h0, rts_o}, 32'h1, "pin after delay");
        if (n >= 20) begin
            tally_and_finish();
        end
        $display("test turnaround delay done");
        wctl(32'h0000_0000);
        @(posedge ref_clk_i);
        modem_rts_i <= 1'b0;
        txw();
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({30'h0, rts_o, dtr_o}, 32'h1, "direction off");
        @(posedge ref_clk_i);
        modem_rts_i <= 1'b1;
        wctl(32'h0000_0010);
        txw();
        check({31'h0, rts_o}, 32'h0, "armed");
        @(posedge ref_clk_i);
        loopback_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({30'h0, rts_o, dtr_o}, 32'h3, "loopback");
        $display("test loopback done");
        tally_and_finish();
    end
endmodule : uart_multidrop_direction_ctrl_tb_top
`default_nettype wire
